// File: common/dsg_pkg.sv
// package for the deep-sleep gating and soft-reset slice
// shared register map, field positions, reset values and power modes
package dsg_pkg;
  localparam int unsigned DSG_AW            = 12;
  localparam int unsigned DSG_DW            = 32;
  localparam int unsigned DSG_NPORT         = 3;
  localparam logic [11:0] DSG_OFF_SRST0     = 12'h040;
  localparam logic [11:0] DSG_OFF_RUN_GATE  = 12'h108;
  localparam logic [11:0] DSG_OFF_SLP_GATE  = 12'h118;
  localparam logic [11:0] DSG_OFF_DSL_GATE  = 12'h128;
  localparam logic [11:0] DSG_OFF_CTRL      = 12'h200;
  localparam logic [11:0] DSG_OFF_INT_STAT  = 12'h204;
  localparam logic [11:0] DSG_OFF_INT_MASK  = 12'h208;
  localparam logic [11:0] DSG_OFF_EFF_GATE  = 12'h20C;
  localparam int unsigned DSG_BIT_WDOG      = 3;
  localparam int unsigned DSG_BIT_AUTO      = 0;
  localparam logic [2:0]  DSG_GATE_RST      = 3'h0;
  localparam logic [2:0]  DSG_PORT_RST      = 3'h0;
  localparam logic        DSG_BIT_RST       = 1'h0;
  localparam logic [31:0] DSG_WORD_RST      = 32'h0000_0000;
  localparam logic [1:0]  DSG_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  DSG_RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    DSG_RUN,
    DSG_SLEEP,
    DSG_DEEP
  } dsg_mode_t;
endpackage

// File: common/dsg_reg_if.sv
// register access carrier between the bus slave and the register file
// one clock domain; the write strobe is single cycle, reads carry only an address
`timescale 1ns/1ps
interface dsg_reg_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
               input wr_err, input rd_data, input rd_err);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
                output wr_err, output rd_data, output rd_err);
endinterface

// File: hw/dsg_axil.sv
// axi4-lite slave front end for the gating slice
// assumes a single clock and an axi4-lite master on the same clock
`timescale 1ns/1ps
module dsg_axil
  import dsg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  dsg_reg_if.bus           rif
);
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_wr;

  assign do_wr       = aw_got_r & w_got_r & ~bvalid;
  assign rif.wr_en   = do_wr;
  assign rif.wr_addr = awaddr_r;
  assign rif.wr_data = wdata_r;
  assign rif.wr_strb = wstrb_r;
  assign rif.rd_addr = araddr;

  // write address channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      awready  <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (awvalid && awready) begin
      aw_got_r <= 1'b1;
      awready  <= 1'b0;
      awaddr_r <= awaddr;
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
      awready  <= 1'b1;
    end else if (!aw_got_r) begin
      awready  <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_got_r <= 1'b0;
      wready  <= 1'b0;
      wdata_r <= DSG_WORD_RST;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      w_got_r <= 1'b1;
      wready  <= 1'b0;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (do_wr) begin
      w_got_r <= 1'b0;
      wready  <= 1'b1;
    end else if (!w_got_r) begin
      wready  <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= DSG_RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= rif.wr_err ? DSG_RESP_SLVERR : DSG_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, data sampled at the address handshake
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= DSG_WORD_RST;
      rresp   <= DSG_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rif.rd_data;
      rresp   <= rif.rd_err ? DSG_RESP_SLVERR : DSG_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  bresp_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");
endmodule

// File: hw/dsg_gate_sel.sv
// port clock enable selection by power mode and auto gating
// assumes mode and gate words come from logic on the same clock
`timescale 1ns/1ps
module dsg_gate_sel
  import dsg_pkg::*;
#(
  parameter int unsigned NPORT = DSG_NPORT
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire dsg_mode_t        mode,
  input  wire logic             auto_sel,
  input  wire logic [NPORT-1:0] run_gate,
  input  wire logic [NPORT-1:0] slp_gate,
  input  wire logic [NPORT-1:0] dsl_gate,
  output logic      [NPORT-1:0] en
);
  logic [NPORT-1:0] en_nxt;

  always_comb begin
    en_nxt = run_gate;
    if (auto_sel) begin
      case (mode)
        DSG_RUN:   en_nxt = run_gate;
        DSG_SLEEP: en_nxt = slp_gate;
        DSG_DEEP:  en_nxt = dsl_gate;
        default:   en_nxt = run_gate;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en <= '0;
    end else begin
      en <= en_nxt;
    end
  end

  deep_gate_a : assert property (@(posedge mclk) disable iff (!rst_n)
    auto_sel && mode == DSG_DEEP |=> en == $past(dsl_gate))
    else $error("deep-sleep enables not taken from deep gate");
  run_only_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !auto_sel |=> en == $past(run_gate))
    else $error("sleep gating applied without auto gating");
  sleep_gate_a : assert property (@(posedge mclk) disable iff (!rst_n)
    auto_sel && mode == DSG_SLEEP |=> en == $past(slp_gate))
    else $error("sleep enables not taken from sleep gate");
endmodule

// File: hw/dsg_top.sv
// deep-sleep port gating and first soft-reset word, top level
// assumes axi4-lite master, power mode and capability word on mclk
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module dsg_top
  import dsg_pkg::*;
#(
  parameter int unsigned NPORT = DSG_NPORT
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [1:0]       pm_mode,
  input  wire logic [31:0]      capability_word_1,
  input  wire logic [NPORT-1:0] port_access,
  output logic      [NPORT-1:0] port_clk_en,
  output logic      [NPORT-1:0] port_fault,
  output logic      [NPORT-1:0] port_ok,
  output logic                  watchdog_hold,
  output logic                  irq
);
  dsg_reg_if rif ();

  logic [NPORT-1:0] run_port_gate_r;
  logic [NPORT-1:0] sleep_port_gate_r;
  logic [NPORT-1:0] deep_sleep_port_gate_r;
  logic             watchdog_reset_bit_r;
  logic             auto_gating_select_r;
  logic [NPORT-1:0] int_stat_r;
  logic [NPORT-1:0] int_mask_r;
  logic [NPORT-1:0] int_stat_nxt;
  logic [NPORT-1:0] int_mask_nxt;
  logic [NPORT-1:0] fault_nxt;
  logic             wr_lo;
  logic             seen_wr_r;
  dsg_mode_t        mode;

  // decode of the mapped register offsets
  function automatic logic dsg_mapped(input logic [11:0] a);
    case (a)
      DSG_OFF_SRST0, DSG_OFF_RUN_GATE, DSG_OFF_SLP_GATE, DSG_OFF_DSL_GATE,
      DSG_OFF_CTRL, DSG_OFF_INT_STAT, DSG_OFF_INT_MASK, DSG_OFF_EFF_GATE: dsg_mapped = 1'b1;
      default: dsg_mapped = 1'b0;
    endcase
  endfunction

  // write hits a register and carries byte 0
  function automatic logic dsg_hit(input logic [11:0] off);
    dsg_hit = wr_lo && (rif.wr_addr == off);
  endfunction

  dsg_axil u_axil (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rif     (rif)
  );

  assign mode  = dsg_mode_t'(pm_mode);
  assign wr_lo = rif.wr_en && rif.wr_strb[0];

  dsg_gate_sel #(.NPORT(NPORT)) u_sel (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .mode     (mode),
    .auto_sel (auto_gating_select_r),
    .run_gate (run_port_gate_r),
    .slp_gate (sleep_port_gate_r),
    .dsl_gate (deep_sleep_port_gate_r),
    .en       (port_clk_en)
  );

  assign rif.wr_err = !dsg_mapped(rif.wr_addr);
  assign rif.rd_err = !dsg_mapped(rif.rd_addr);

  // read mux, unused bits read zero
  always_comb begin
    rif.rd_data = DSG_WORD_RST;
    case (rif.rd_addr)
      DSG_OFF_SRST0:    rif.rd_data[DSG_BIT_WDOG] = watchdog_reset_bit_r;
      DSG_OFF_RUN_GATE: rif.rd_data[NPORT-1:0]   = run_port_gate_r;
      DSG_OFF_SLP_GATE: rif.rd_data[NPORT-1:0]   = sleep_port_gate_r;
      DSG_OFF_DSL_GATE: rif.rd_data[NPORT-1:0]   = deep_sleep_port_gate_r;
      DSG_OFF_CTRL:     rif.rd_data[DSG_BIT_AUTO] = auto_gating_select_r;
      DSG_OFF_INT_STAT: rif.rd_data[NPORT-1:0]   = int_stat_r;
      DSG_OFF_INT_MASK: rif.rd_data[NPORT-1:0]   = int_mask_r;
      DSG_OFF_EFF_GATE: rif.rd_data[NPORT-1:0]   = port_clk_en;
      default:          rif.rd_data              = DSG_WORD_RST;
    endcase
  end

  // gate registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_port_gate_r        <= DSG_GATE_RST;
      sleep_port_gate_r      <= DSG_GATE_RST;
      deep_sleep_port_gate_r <= DSG_GATE_RST;
    end else begin
      if (dsg_hit(DSG_OFF_RUN_GATE)) begin
        run_port_gate_r <= rif.wr_data[NPORT-1:0];
      end
      if (dsg_hit(DSG_OFF_SLP_GATE)) begin
        sleep_port_gate_r <= rif.wr_data[NPORT-1:0];
      end
      if (dsg_hit(DSG_OFF_DSL_GATE)) begin
        deep_sleep_port_gate_r <= rif.wr_data[NPORT-1:0];
      end
    end
  end

  // auto gating select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_gating_select_r <= DSG_BIT_RST;
    end else if (dsg_hit(DSG_OFF_CTRL)) begin
      auto_gating_select_r <= rif.wr_data[DSG_BIT_AUTO];
    end
  end

  // soft reset word, masked by capability word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_reset_bit_r <= DSG_BIT_RST;
    end else if (dsg_hit(DSG_OFF_SRST0)) begin
      watchdog_reset_bit_r <= rif.wr_data[DSG_BIT_WDOG] & capability_word_1[DSG_BIT_WDOG];
    end
  end

  // watchdog held in reset while the bit is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_hold <= 1'b0;
    end else begin
      watchdog_hold <= watchdog_reset_bit_r;
    end
  end

  // port access answers
  assign fault_nxt = port_access & ~port_clk_en;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_fault <= DSG_PORT_RST;
      port_ok    <= DSG_PORT_RST;
    end else begin
      port_fault <= fault_nxt;
      port_ok    <= port_access & port_clk_en;
    end
  end

  // sticky fault status, set wins over write-one clear
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (dsg_hit(DSG_OFF_INT_STAT)) begin
      int_stat_nxt = int_stat_nxt & ~rif.wr_data[NPORT-1:0];
    end
    int_stat_nxt = int_stat_nxt | fault_nxt;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= DSG_PORT_RST;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  // mask next value, so irq follows a mask write at once
  always_comb begin
    int_mask_nxt = int_mask_r;
    if (dsg_hit(DSG_OFF_INT_MASK)) begin
      int_mask_nxt = rif.wr_data[NPORT-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_r <= DSG_PORT_RST;
    end else begin
      int_mask_r <= int_mask_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_nxt & int_mask_nxt);
    end
  end

  // helper for the reset-value check
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seen_wr_r <= 1'b0;
    end else if (rif.wr_en) begin
      seen_wr_r <= 1'b1;
    end
  end

  gate_fault_a : assert property (@(posedge mclk) disable iff (!rst_n)
    port_access[0] && !port_clk_en[0] |=> port_fault[0] && !port_ok[0] && int_stat_r[0])
    else $error("gated port access not faulted");

  reset_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !seen_wr_r |-> run_port_gate_r == 3'h0 && deep_sleep_port_gate_r == 3'h0 && port_clk_en == 3'h0)
    else $error("gate enables not zero after reset");

  dsg_ro_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.rd_addr == 12'h128 |-> rif.rd_data[31:3] == 29'h0 && !rif.rd_err)
    else $error("deep gate reserved bits not zero");

  dsg_decode_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.wr_en && rif.wr_strb[0] && rif.wr_addr == 12'h128
      |=> deep_sleep_port_gate_r == $past(rif.wr_data[2:0]))
    else $error("deep gate write not stored");

  run_decode_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.wr_en && rif.wr_strb[0] && rif.wr_addr == 12'h108
      |=> run_port_gate_r == $past(rif.wr_data[2:0]))
    else $error("run gate write not stored");

  wdog_mask_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.wr_en && rif.wr_strb[0] && rif.wr_addr == 12'h040 && !capability_word_1[3]
      |=> !watchdog_reset_bit_r ##1 !watchdog_hold)
    else $error("soft reset write not masked");

  wdog_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.wr_en && rif.wr_strb[0] && rif.wr_addr == 12'h040 && rif.wr_data[3] && capability_word_1[3]
      |=> ##1 watchdog_hold)
    else $error("watchdog not held after reset bit set");

  srst_ro_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.rd_addr == 12'h040 |-> rif.rd_data[31:4] == 28'h0 && rif.rd_data[2:0] == 3'h0)
    else $error("soft reset reserved bits not zero");

  wdog_bit_a : assert property (@(posedge mclk) disable iff (!rst_n)
    rif.rd_addr == 12'h040 |-> rif.rd_data[3] == watchdog_reset_bit_r)
    else $error("watchdog bit not at position 3");

  irq_level_a : assert property (@(posedge mclk) disable iff (!rst_n)
    irq == |(int_stat_r & int_mask_r))
    else $error("interrupt level differs from unmasked status");
endmodule

// File: bench/dsg_tb_top.sv
// self-checking bench for the deep-sleep gating and soft-reset slice
// assumes dsg_top alone on one 50 MHz clock; the bench is the axi4-lite master
`timescale 1ns/1ps
module dsg_tb_top;
  import dsg_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [11:0] aw_addr;
  logic        aw_valid;
  logic        aw_ready;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_valid;
  logic        w_ready;
  logic [1:0]  b_resp;
  logic        b_valid;
  logic        b_ready;
  logic [11:0] ar_addr;
  logic        ar_valid;
  logic        ar_ready;
  logic [31:0] r_data;
  logic [1:0]  r_resp;
  logic        r_valid;
  logic        r_ready;
  logic [1:0]  pm_mode;
  logic [31:0] cap_word;
  logic [2:0]  port_access;
  logic [2:0]  port_clk_en;
  logic [2:0]  port_fault;
  logic [2:0]  port_ok;
  logic        watchdog_hold;
  logic        irq;
  int          error_cnt;
  int          check_count;
  int          cycle_cnt;
  integer      seed;

  dsg_top dut_u (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
    .pm_mode(pm_mode), .capability_word_1(cap_word), .port_access(port_access),
    .port_clk_en(port_clk_en), .port_fault(port_fault), .port_ok(port_ok),
    .watchdog_hold(watchdog_hold), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cuts a hang short
  always @(posedge mclk) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    aw_addr  <= a;
    aw_valid <= 1'b1;
    w_data   <= d;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid && b_ready) begin
        r = b_resp;
        b_ready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid && r_ready) begin
        d = r_data;
        r = r_resp;
        r_ready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, DSG_RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, DSG_RESP_OKAY});
    check(what, d, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [2:0] exp_en(input logic [2:0] rg, input logic [2:0] sg, input logic [2:0] dg,
                                        input logic a, input logic [1:0] m);
    if (!a) return rg;
    if (m == 2'h1) return sg;
    if (m == 2'h2) return dg;
    return rg;
  endfunction

  task automatic pulse(input logic [2:0] acc);
    @(posedge mclk);
    port_access <= acc;
    @(posedge mclk);
    port_access <= 3'h0;
    #1;
  endtask

  initial begin
    logic [31:0] d;
    logic [31:0] cap;
    logic [31:0] rg;
    logic [31:0] sg;
    logic [31:0] dg;
    logic [31:0] rnd;
    logic [2:0]  en;
    logic [2:0]  acc;
    logic [1:0]  r;
    logic        a;
    logic [1:0]  m;
    seed = 32'hDF1C;
    error_cnt = 0;
    check_count = 0;
    cycle_cnt = 0;
    rst_n = 1'b0;
    aw_addr <= 12'h000; aw_valid <= 1'b0; w_data <= 32'h0; w_strb <= 4'hF; w_valid <= 1'b0;
    b_ready <= 1'b0; ar_addr <= 12'h000; ar_valid <= 1'b0; r_ready <= 1'b0;
    pm_mode <= 2'h0; cap_word <= 32'h0; port_access <= 3'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    settle(1);
    check("port_clk_en", {29'h0, port_clk_en}, 32'h0);
    check("watchdog_hold", {31'h0, watchdog_hold}, 32'h0);
    rd_chk(DSG_OFF_SRST0, DSG_WORD_RST, "soft_reset_word_0");
    rd_chk(DSG_OFF_RUN_GATE, DSG_WORD_RST, "run_port_gate");
    rd_chk(DSG_OFF_SLP_GATE, DSG_WORD_RST, "sleep_port_gate");
    rd_chk(DSG_OFF_DSL_GATE, DSG_WORD_RST, "deep_sleep_port_gate");
    $display("test reset_values done");
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      cap = $random(seed);
      if (i < 2) d = 32'hFFFF_FFFF;
      if (i == 0) cap = 32'hFFFF_FFFF;
      if (i == 1) cap = 32'hFFFF_FFF7;
      cap_word <= cap;
      wr(DSG_OFF_DSL_GATE, d);
      rd_chk(DSG_OFF_DSL_GATE, d & 32'h7, "deep_sleep_port_gate");
      wr(DSG_OFF_RUN_GATE, ~d);
      rd_chk(DSG_OFF_RUN_GATE, ~d & 32'h7, "run_port_gate");
      wr(DSG_OFF_SRST0, d);
      rd_chk(DSG_OFF_SRST0, d & cap & 32'h8, "soft_reset_word_0");
      settle(2);
      check("watchdog_hold", {31'h0, watchdog_hold}, {31'h0, d[3] & cap[3]});
    end
    axi_wr(12'h300, 32'hFFFF_FFFF, r);
    check("bresp unmapped", {30'h0, r}, {30'h0, DSG_RESP_SLVERR});
    axi_rd(12'h12C, d, r);
    check("rresp unmapped", {30'h0, r}, {30'h0, DSG_RESP_SLVERR});
    check("rdata unmapped", d, 32'h0);
    axi_rd(DSG_OFF_DSL_GATE, d, r);
    check("rresp", {30'h0, r}, {30'h0, DSG_RESP_OKAY});
    wr(DSG_OFF_DSL_GATE, (d & ~32'h7) | 32'h5);
    rd_chk(DSG_OFF_DSL_GATE, 32'h5, "deep_sleep_port_gate");
    w_strb <= 4'hE;
    wr(DSG_OFF_DSL_GATE, 32'h2);
    w_strb <= 4'hF;
    rd_chk(DSG_OFF_DSL_GATE, 32'h5, "deep gate strobe off");
    $display("test register_access done");
    wr(DSG_OFF_INT_MASK, 32'h7);
    for (int i = 0; i < 24; i++) begin
      rg = $random(seed);
      sg = $random(seed);
      dg = $random(seed);
      rnd = $random(seed);
      a = rnd[4];
      m = rnd[1:0];
      if (i < 4) a = 1'b1;
      if (i < 4) m = i[1:0];
      wr(DSG_OFF_RUN_GATE, rg);
      wr(DSG_OFF_SLP_GATE, sg);
      wr(DSG_OFF_DSL_GATE, dg);
      wr(DSG_OFF_CTRL, {31'h0, a});
      pm_mode <= m;
      settle(2);
      en = exp_en(rg[2:0], sg[2:0], dg[2:0], a, m);
      check("port_clk_en", {29'h0, port_clk_en}, {29'h0, en});
      rd_chk(DSG_OFF_EFF_GATE, {29'h0, en}, "effective gate");
      wr(DSG_OFF_INT_STAT, 32'h7);
      acc = rnd[10:8];
      pulse(acc);
      check("port_fault", {29'h0, port_fault}, {29'h0, acc & ~en});
      check("port_ok", {29'h0, port_ok}, {29'h0, acc & en});
      settle(1);
      check("irq", {31'h0, irq}, {31'h0, |(acc & ~en)});
      rd_chk(DSG_OFF_INT_STAT, {29'h0, acc & ~en}, "interrupt status");
    end
    $display("test gate_select done");
    wr(DSG_OFF_INT_MASK, 32'h0);
    wr(DSG_OFF_CTRL, 32'h0);
    wr(DSG_OFF_RUN_GATE, 32'h0);
    settle(2);
    pulse(3'h7);
    check("port_fault", {29'h0, port_fault}, 32'h7);
    settle(1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(DSG_OFF_INT_MASK, 32'h7);
    settle(2);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(DSG_OFF_INT_STAT, 32'h7);
    settle(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk(DSG_OFF_INT_STAT, 32'h0, "interrupt status");
    $display("test interrupt done");
    finish_test();
  end
endmodule
